// ### gpib_flags_pkg.sv
/*
 * Constants shared by the bus-interface flag block and its pin synchroniser.
 * Assumes a single 125 MHz clock and a word-free 4-bit register port.
 */
package gpib_flags_pkg;

    localparam int          ADDR_W        = 4;
    localparam int          DATA_W        = 8;
    localparam int          SYNC_STAGES   = 3;

    // Register offsets
    localparam logic [3:0]  OFS_CTRL      = 4'h0;
    localparam logic [3:0]  OFS_STATUS    = 4'h1;
    localparam logic [3:0]  OFS_SW_LOWER  = 4'h2;
    localparam logic [3:0]  OFS_SW_UPPER  = 4'h3;

    // Control register write bits (command strobes plus one stored level)
    localparam int          CTL_REN_SET   = 0;
    localparam int          CTL_REN_CLR   = 1;
    localparam int          CTL_SPL_SET   = 2;
    localparam int          CTL_SPL_CLR   = 3;
    localparam int          CTL_SRQ       = 4;

    // Status register bit positions
    localparam int          ST_REN_FLAG   = 0;
    localparam int          ST_SPL_FLAG   = 1;
    localparam int          ST_TALK       = 2;
    localparam int          ST_LISTEN     = 3;
    localparam int          ST_REMOTE     = 4;
    localparam int          ST_IFC        = 5;
    localparam int          ST_REN_LINE   = 6;
    localparam int          ST_SRQ        = 7;

    // Upper switch readback bit positions
    localparam int          UP_SW_E       = 0;
    localparam int          UP_LON        = 1;
    localparam int          UP_TON        = 2;
    localparam int          UP_SRQ        = 3;

    // Synchronised pin vector layout
    localparam int          PIN_REN_N     = 0;
    localparam int          PIN_IFC_N     = 1;
    localparam int          PIN_SW_LO     = 2;
    localparam int          PIN_LON       = 7;
    localparam int          PIN_TON       = 8;
    localparam int          PIN_W         = 9;

    // Reset values
    localparam logic [8:0]  PIN_RST_VAL   = 9'h1FF;
    localparam logic [7:0]  RDATA_RST_VAL = 8'h00;

endpackage : gpib_flags_pkg

// ### pin_sync_if.sv
/*
 * Bundle between the flag block and its pin synchroniser.
 * Assumes raw pins arrive asynchronously; clean is in the clk domain.
 */
`timescale 1ns/1ps
interface pin_sync_if #(parameter int W = 9);
    logic [W-1:0] raw;
    logic [W-1:0] clean;

    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface : pin_sync_if

// ### pin_sync.sv
/*
 * Three-stage pin synchroniser; a change is accepted once the second
 * and third stages agree. Assumes pins idle at the reset value.
 */
`timescale 1ns/1ps
module pin_sync
    import gpib_flags_pkg::*;
#(
    parameter int             W       = PIN_W,
    parameter logic [W-1:0]   RST_VAL = PIN_RST_VAL
) (
    input  wire logic clk,
    input  wire logic rst,
    pin_sync_if.sync  pins
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] clean_reg;
    logic [W-1:0] clean_next;
    logic [W-1:0] agree;

    assign agree      = ~(s2_reg ^ s3_reg);
    assign clean_next = (agree & s3_reg) | (~agree & clean_reg);
    assign pins.clean = clean_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_reg    <= RST_VAL;
            s2_reg    <= RST_VAL;
            s3_reg    <= RST_VAL;
            clean_reg <= RST_VAL;
        end else begin
            s1_reg    <= pins.raw;
            s2_reg    <= s1_reg;
            s3_reg    <= s2_reg;
            clean_reg <= clean_next;
        end
    end

endmodule : pin_sync

// ### gpib_flags.sv
/*
 * Interface-side control flags of an instrument bus port: remote enable,
 * serial poll, talk and listen flags, service request drive and the
 * address switch readback. Assumes the handshake and command decode sit
 * outside and present one-cycle pulses on clk; bus pins are asynchronous.
 */
`timescale 1ns/1ps
module gpib_flags
    import gpib_flags_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              ren_n,
    input  wire logic              ifc_n,
    input  wire logic [4:0]        bus_address_switches,
    input  wire logic              talk_only_switch,
    input  wire logic              listen_only_switch,
    input  wire logic              my_talk_addr,
    input  wire logic              my_listen_addr,
    input  wire logic              untalk_cmd,
    input  wire logic              unlisten_cmd,
    input  wire logic              spe_cmd,
    input  wire logic              spd_cmd,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    output logic                   cpu_int,
    output logic                   srq_n_o,
    output logic                   srq_n_oe,
    output logic                   remote_led,
    output logic                   talk_flag,
    output logic                   listen_flag,
    output logic                   send_status_byte
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    pin_sync_if #(.W(PIN_W)) pins ();

    // The end-of-message line has no input here; no flag sees it
    assign pins.raw = {talk_only_switch, listen_only_switch,
                       bus_address_switches, ifc_n, ren_n};

    pin_sync #(.W(PIN_W), .RST_VAL(PIN_RST_VAL)) u_sync (
        .clk  (clk),
        .rst  (rst),
        .pins (pins)
    );

    logic       ren_true;
    logic       ifc_true;
    logic [4:0] sw_addr;
    logic       sw_ton;
    logic       sw_lon;

    assign ren_true = ~pins.clean[PIN_REN_N];
    assign ifc_true = ~pins.clean[PIN_IFC_N];
    assign sw_addr  = pins.clean[PIN_SW_LO +: 5];
    assign sw_ton   = pins.clean[PIN_TON];
    assign sw_lon   = pins.clean[PIN_LON];

    ////////////////////////////////////////////////////////////////////////
    // Register port decode

    logic       sel_ctrl;
    logic       sel_status;
    logic       readback_select_lower;
    logic       readback_select_upper;
    logic       ctrl_wr;
    logic       ren_set_cmd;
    logic       ren_clr_cmd;
    logic       spl_set_cmd;
    logic       spl_clr_cmd;

    assign sel_ctrl              = reg_addr == OFS_CTRL;
    assign sel_status            = reg_addr == OFS_STATUS;
    assign readback_select_lower = reg_rd && reg_addr == OFS_SW_LOWER;
    assign readback_select_upper = reg_rd && reg_addr == OFS_SW_UPPER;
    assign ctrl_wr               = reg_wr && sel_ctrl;
    assign ren_set_cmd           = ctrl_wr && reg_wdata[CTL_REN_SET];
    assign ren_clr_cmd           = ctrl_wr && reg_wdata[CTL_REN_CLR];
    assign spl_set_cmd           = ctrl_wr && reg_wdata[CTL_SPL_SET];
    assign spl_clr_cmd           = ctrl_wr && reg_wdata[CTL_SPL_CLR];

    ////////////////////////////////////////////////////////////////////////
    // Flag next-state logic

    logic ren_flag_reg;
    logic ren_flag_next;
    logic spl_flag_reg;
    logic spl_flag_next;
    logic talk_reg;
    logic talk_next;
    logic listen_reg;
    logic listen_next;
    logic remote_reg;
    logic remote_next;
    logic srq_reg;
    logic srq_next;
    logic stsel_reg;
    logic stsel_next;
    logic int_reg;
    logic int_next;
    logic cmp_en;

    // Hardware holds win; a set beats a clear in the same cycle
    assign ren_flag_next = !ren_true ? 1'b0 :
                           ren_set_cmd ? 1'b1 :
                           ren_clr_cmd ? 1'b0 : ren_flag_reg;

    assign spl_flag_next = ifc_true ? 1'b0 :
                           spl_set_cmd ? 1'b1 :
                           spl_clr_cmd ? 1'b0 : spl_flag_reg;

    // Address comparator is disabled while IFC is true
    assign cmp_en = !ifc_true;

    assign talk_next   = ifc_true ? 1'b0 :
                         (cmp_en && my_talk_addr) ? 1'b1 :
                         (cmp_en && (untalk_cmd || my_listen_addr)) ? 1'b0 :
                         talk_reg;
    assign listen_next = ifc_true ? 1'b0 :
                         (cmp_en && my_listen_addr) ? 1'b1 :
                         (cmp_en && unlisten_cmd) ? 1'b0 :
                         listen_reg;

    // Remote mode follows listen addressing with remote enable granted
    assign remote_next = !ren_flag_reg ? 1'b0 :
                         listen_reg ? 1'b1 : remote_reg;

    assign srq_next = ctrl_wr ? reg_wdata[CTL_SRQ] : srq_reg;

    // Talk addressing latches which data source is sent
    assign stsel_next = !talk_next ? 1'b0 :
                        (cmp_en && my_talk_addr) ? spl_flag_reg :
                        stsel_reg;

    assign int_next = cmp_en &&
                      (my_listen_addr || spe_cmd || spd_cmd);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ren_flag_reg <= 1'b0;
            spl_flag_reg <= 1'b0;
            talk_reg     <= 1'b0;
            listen_reg   <= 1'b0;
            remote_reg   <= 1'b0;
            srq_reg      <= 1'b0;
            stsel_reg    <= 1'b0;
            int_reg      <= 1'b0;
        end else begin
            ren_flag_reg <= ren_flag_next;
            spl_flag_reg <= spl_flag_next;
            talk_reg     <= talk_next;
            listen_reg   <= listen_next;
            remote_reg   <= remote_next;
            srq_reg      <= srq_next;
            stsel_reg    <= stsel_next;
            int_reg      <= int_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data

    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] lower_word;
    logic [DATA_W-1:0] upper_word;
    logic [DATA_W-1:0] rdata_next;
    logic [DATA_W-1:0] rdata_reg;

    assign status_word = {srq_reg, ren_true, ifc_true, remote_reg,
                          listen_reg, talk_reg, spl_flag_reg, ren_flag_reg};
    assign lower_word  = {4'h0, sw_addr[3:0]};
    assign upper_word  = {4'h0, srq_reg, sw_ton, sw_lon,
                          sw_addr[4]};

    // Each select strobe gates only its own switch group
    assign rdata_next = (reg_rd && sel_status) ? status_word :
                        readback_select_lower  ? lower_word :
                        readback_select_upper  ? upper_word :
                        (reg_rd && sel_ctrl)   ? {3'h0, srq_reg, 4'h0} :
                        RDATA_RST_VAL;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= RDATA_RST_VAL;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    logic srq_oe_reg;
    logic srq_o_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            srq_oe_reg <= 1'b0;
            srq_o_reg  <= 1'b0;
        end else begin
            srq_oe_reg <= srq_next;
            srq_o_reg  <= 1'b0;
        end
    end

    assign reg_rdata        = rdata_reg;
    assign cpu_int          = int_reg;
    assign srq_n_o          = srq_o_reg;
    assign srq_n_oe         = srq_oe_reg;
    assign remote_led       = remote_reg;
    assign talk_flag        = talk_reg;
    assign listen_flag      = listen_reg;
    assign send_status_byte = stsel_reg;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    AST_REN_HELD: assert property (@(posedge clk) disable iff (rst)
        !ren_true |=> !ren_flag_reg)
        else $error("remote enable flag set while REN false");

    AST_REN_SET: assert property (@(posedge clk) disable iff (rst)
        (ren_true && ren_set_cmd) |=> ren_flag_reg)
        else $error("remote enable flag not set on command");

    AST_LISTEN_INT: assert property (@(posedge clk) disable iff (rst)
        (my_listen_addr && !ifc_true) |=> cpu_int)
        else $error("no interrupt on listen address");

    AST_REMOTE: assert property (@(posedge clk) disable iff (rst)
        remote_led |-> $past(ren_flag_reg))
        else $error("remote mode without remote enable flag");

    AST_REMOTE_ON: assert property (@(posedge clk) disable iff (rst)
        (listen_flag && ren_flag_reg && ren_true) |=> remote_led)
        else $error("remote mode not entered");

    AST_SPE_INT: assert property (@(posedge clk) disable iff (rst)
        (spe_cmd && !ifc_true) |=> cpu_int)
        else $error("no interrupt on serial poll enable");

    AST_SPL_IFC: assert property (@(posedge clk) disable iff (rst)
        ifc_true |=> !spl_flag_reg)
        else $error("serial poll flag set during IFC");

    AST_STSEL: assert property (@(posedge clk) disable iff (rst)
        (my_talk_addr && !ifc_true) |=> send_status_byte == $past(spl_flag_reg))
        else $error("wrong data source chosen on talk address");

    AST_SPL_CLR: assert property (@(posedge clk) disable iff (rst)
        (spl_clr_cmd && !spl_set_cmd) |=> !spl_flag_reg)
        else $error("serial poll flag not cleared");

    AST_SRQ: assert property (@(posedge clk) disable iff (rst)
        $rose(srq_n_oe) |-> $past(ctrl_wr) && $past(reg_wdata[CTL_SRQ])
            && !srq_n_o)
        else $error("SRQ driven without command");

    AST_IFC_FLAGS: assert property (@(posedge clk) disable iff (rst)
        ifc_true |=> !talk_flag && !listen_flag)
        else $error("talk or listen flag alive during IFC");

    AST_RB_UPPER: assert property (@(posedge clk) disable iff (rst)
        readback_select_upper |=> reg_rdata[UP_SRQ] == $past(srq_reg))
        else $error("upper readback lacks service request state");

    AST_RB_LOWER: assert property (@(posedge clk) disable iff (rst)
        readback_select_lower |=> reg_rdata[7:4] == 4'h0
            && reg_rdata[3:0] == $past(sw_addr[3:0]))
        else $error("lower readback shows wrong switch group");

    AST_RB_IDLE: assert property (@(posedge clk) disable iff (rst)
        !reg_rd |=> reg_rdata == RDATA_RST_VAL)
        else $error("read data driven without a read strobe");

    AST_SPD_INT: assert property (@(posedge clk) disable iff (rst)
        (spd_cmd && !ifc_true) |=> cpu_int)
        else $error("no interrupt on serial poll disable");

    AST_SPL_SET: assert property (@(posedge clk) disable iff (rst)
        (spl_set_cmd && !ifc_true) |=> spl_flag_reg)
        else $error("serial poll flag not set while IFC false");

endmodule : gpib_flags

// ### bus_ctrl_model.sv
/*
 * Behavioural far-side bus controller: turns a command byte into the
 * one-cycle decode pulses and resolves the pulled-up service request wire.
 * Assumes one clock shared with the flag block; requests last one cycle.
 */
`timescale 1ns/1ps
module bus_ctrl_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       req,
    input  wire logic [7:0] req_byte,
    input  wire logic [4:0] my_addr,
    input  wire logic       srq_n_o,
    input  wire logic       srq_n_oe,
    output wire logic       srq_line,
    output logic            my_talk_addr,
    output logic            my_listen_addr,
    output logic            untalk_cmd,
    output logic            unlisten_cmd,
    output logic            spe_cmd,
    output logic            spd_cmd
);
    ////////////////////////////////////////////////////////////////////////
    wire logic       is_talk   = req & (req_byte[6:5] == 2'b10);
    wire logic       is_listen = req & (req_byte[6:5] == 2'b01);
    wire logic [4:0] cmd_addr  = req_byte[4:0];

    // Released wire floats to the pull-up level
    assign srq_line = srq_n_oe ? srq_n_o : 1'b1;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {my_talk_addr, my_listen_addr, untalk_cmd} <= 3'h0;
            {unlisten_cmd, spe_cmd, spd_cmd}           <= 3'h0;
        end else begin
            my_talk_addr   <= is_talk & (cmd_addr == my_addr);
            my_listen_addr <= is_listen & (cmd_addr == my_addr);
            untalk_cmd     <= is_talk & (cmd_addr == 5'h1F);
            unlisten_cmd   <= is_listen & (cmd_addr == 5'h1F);
            spe_cmd        <= req & (req_byte == 8'h18);
            spd_cmd        <= req & (req_byte == 8'h19);
        end
    end
endmodule : bus_ctrl_model

// ### tb.sv
/*
 * Self-checking bench for the bus-interface flag block.
 * Assumes the far-side model above and pins that settle within 6 cycles.
 */
`timescale 1ns/1ps
module tb;
    import gpib_flags_pkg::*;
    logic clk = 1'b0, rst = 1'b1, ren_n = 1'b1, ifc_n = 1'b1;
    logic [4:0] sw = 5'h1C;
    logic ton = 1'b0, lon = 1'b0, req = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] req_byte = 8'h00, reg_wdata = 8'h00, int_cnt, n0;
    logic [ADDR_W-1:0] reg_addr = 4'h0;
    logic [DATA_W-1:0] reg_rdata;
    logic cpu_int, srq_n_o, srq_n_oe, srq_line, remote_led, talk_flag;
    logic listen_flag, sbs, mta, mla, unt, unl, spe, spd;
    int error_cnt = 0, num_checks = 0, cyc = 0;

    always #4 clk = ~clk;

    bus_ctrl_model FAR (.clk(clk), .rst(rst), .req(req), .req_byte(req_byte),
        .my_addr(sw), .srq_n_o(srq_n_o), .srq_n_oe(srq_n_oe),
        .srq_line(srq_line), .my_talk_addr(mta), .my_listen_addr(mla),
        .untalk_cmd(unt), .unlisten_cmd(unl), .spe_cmd(spe), .spd_cmd(spd));

    gpib_flags DUT (.clk(clk), .rst(rst), .ren_n(ren_n), .ifc_n(ifc_n),
        .bus_address_switches(sw), .talk_only_switch(ton),
        .listen_only_switch(lon), .my_talk_addr(mta), .my_listen_addr(mla),
        .untalk_cmd(unt), .unlisten_cmd(unl), .spe_cmd(spe), .spd_cmd(spd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_int(cpu_int),
        .srq_n_o(srq_n_o), .srq_n_oe(srq_n_oe), .remote_led(remote_led),
        .talk_flag(talk_flag), .listen_flag(listen_flag),
        .send_status_byte(sbs));

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk or posedge rst) begin
        if (rst) int_cnt <= 8'h00;
        else if (cpu_int === 1'b1) int_cnt <= int_cnt + 8'h01;
    end

    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            $display("Run exceeded its cycle ceiling");
            error_cnt = error_cnt + 1;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            error_cnt = error_cnt + 1;
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            error_cnt = error_cnt + 1;
        end
    endtask : chk1

    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
    endtask : waitc

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the taking edge
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk8(reg_rdata, exp);
        @(posedge clk);
    endtask : rd_chk

    task automatic send(input logic [7:0] b);
        @(posedge clk);
        req <= 1'b1;
        req_byte <= b;
        @(posedge clk);
        req <= 1'b0;
        waitc(3);
    endtask : send

    ////////////////////////////////////////////////////////////////////////
    initial begin
        waitc(4);
        rst <= 1'b0;
        waitc(6);
        rd_chk(OFS_STATUS, 8'h00);
        chk1(srq_n_oe, 1'b0);
        $display("test reset done");
        n0 = int_cnt;
        send(8'h3C);
        chk1(listen_flag, 1'b1);
        chk8(int_cnt, n0 + 8'h01);
        wr(OFS_CTRL, 8'h01);
        rd_chk(OFS_STATUS, 8'h08);
        ren_n <= 1'b0;
        waitc(6);
        wr(OFS_CTRL, 8'h01);
        waitc(2);
        rd_chk(OFS_STATUS, 8'h59);
        chk1(remote_led, 1'b1);
        ren_n <= 1'b1;
        waitc(6);
        rd_chk(OFS_STATUS, 8'h08);
        send(8'h3F);
        ren_n <= 1'b0;
        waitc(6);
        wr(OFS_CTRL, 8'h01);
        waitc(2);
        chk1(remote_led, 1'b0);
        rd_chk(OFS_STATUS, 8'h41);
        wr(OFS_CTRL, 8'h02);
        ren_n <= 1'b1;
        waitc(6);
        $display("test remote done");
        n0 = int_cnt;
        send(8'h18);
        chk8(int_cnt, n0 + 8'h01);
        wr(OFS_CTRL, 8'h04);
        send(8'h5C);
        chk1(sbs, 1'b1);
        rd_chk(OFS_STATUS, 8'h06);
        n0 = int_cnt;
        send(8'h19);
        chk8(int_cnt, n0 + 8'h01);
        wr(OFS_CTRL, 8'h08);
        rd_chk(OFS_STATUS, 8'h04);
        send(8'h5F);
        chk1(talk_flag, 1'b0);
        send(8'h5C);
        chk1(sbs, 1'b0);
        $display("test spoll done");
        wr(OFS_CTRL, 8'h04);
        send(8'h3C);
        send(8'h5C);
        ifc_n <= 1'b0;
        waitc(6);
        rd_chk(OFS_STATUS, 8'h20);
        n0 = int_cnt;
        send(8'h3C);
        send(8'h5C);
        chk1(listen_flag | talk_flag, 1'b0);
        chk8(int_cnt, n0);
        wr(OFS_CTRL, 8'h04);
        rd_chk(OFS_STATUS, 8'h20);
        ifc_n <= 1'b1;
        waitc(6);
        wr(OFS_CTRL, 8'h04);
        rd_chk(OFS_STATUS, 8'h02);
        wr(OFS_CTRL, 8'h08);
        $display("test ifc done");
        wr(OFS_CTRL, 8'h10);
        waitc(1);
        chk1(srq_line, 1'b0);
        rd_chk(OFS_SW_UPPER, 8'h09);
        rd_chk(OFS_STATUS, 8'h80);
        rd_chk(OFS_CTRL, 8'h10);
        wr(OFS_CTRL, 8'h00);
        waitc(1);
        chk1(srq_line, 1'b1);
        $display("test srq done");
        wr(OFS_CTRL, 8'h14);
        rd_chk(OFS_STATUS, 8'h82);
        rst <= 1'b1;
        waitc(2);
        rst <= 1'b0;
        waitc(6);
        rd_chk(OFS_STATUS, 8'h00);
        chk1(srq_line, 1'b1);
        $display("test second reset done");
        sw <= 5'h15;
        ton <= 1'b1;
        waitc(6);
        rd_chk(OFS_SW_LOWER, 8'h05);
        rd_chk(OFS_SW_UPPER, 8'h05);
        sw <= 5'h0A;
        ton <= 1'b0;
        lon <= 1'b1;
        waitc(6);
        rd_chk(OFS_SW_LOWER, 8'h0A);
        rd_chk(OFS_SW_UPPER, 8'h02);
        rd_chk(4'hF, 8'h00);
        wr(4'hE, 8'hFF);
        rd_chk(OFS_STATUS, 8'h00);
        $display("test switches done");
        wrap_up();
    end
endmodule : tb
